/* File: src/bpsl_classify.sv */
// bpsl_classify: decides which parity status bits an error event sets.
// assumes event fields are stable in the cycle that valid is high.
`timescale 1ns/1ps
`default_nettype none
module bpsl_classify
   import bpsl_pkg::*;
(
   // event and bus state
   input wire bpsl_err_s err,
   input wire bpsl_bus_s bus,
   // enables
   input wire logic pri_per,
   input wire logic sec_per,
   // set requests
   output logic [BPSL_NSTAT-1:0] set
);

   function automatic logic is_write(input bpsl_kind_e k);
      is_write = (k == BPSL_POSTED_WR) || (k == BPSL_DELAYED_WR);
   endfunction : is_write

   always_comb
   begin
      set = BPSL_STAT_RST;
      // enables deliberately not consulted for detected bits
      set[BPSL_BIT_PRI_DET] = err.valid && !err.on_secondary &&
         ((err.upstream && err.kind == BPSL_READ) ||
          (!err.upstream && is_write(err.kind)));
      set[BPSL_BIT_SEC_DET] = err.valid && err.on_secondary &&
         ((!err.upstream && err.kind == BPSL_READ) ||
          (err.upstream && is_write(err.kind)));
      // master bits: pin sampled while mastering, or an error event of any kind, upstream on primary or downstream on secondary
      set[BPSL_BIT_PRI_MDP] = pri_per && bus.pri_master &&
         (bus.pri_pin || (err.valid && !err.on_secondary && err.upstream));
      set[BPSL_BIT_SEC_MDP] = sec_per && bus.sec_master &&
         (bus.sec_pin || (err.valid && err.on_secondary && !err.upstream));
   end

endmodule : bpsl_classify
`default_nettype wire

/* File: src/bpsl_pkg.sv */
// bpsl_pkg: constants, types and register map of the bridge parity status logic.
// assumes one clock domain and an axi4-lite register slave in the top module.
package bpsl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [3:0] BPSL_ADDR_STATUS = 4'h0;
   localparam logic [3:0] BPSL_ADDR_MASK = 4'h4;
   localparam logic [3:0] BPSL_ADDR_CTRL = 4'h8;
   localparam logic [3:0] BPSL_ADDR_INFO = 4'hC;

   // status and mask field positions
   localparam int BPSL_BIT_PRI_DET = 0;
   localparam int BPSL_BIT_SEC_DET = 1;
   localparam int BPSL_BIT_PRI_MDP = 2;
   localparam int BPSL_BIT_SEC_MDP = 3;
   localparam int BPSL_NSTAT = 4;

   // control field positions
   localparam int BPSL_BIT_PRI_PER = 0;
   localparam int BPSL_BIT_SEC_PER = 1;

   localparam logic [BPSL_NSTAT-1:0] BPSL_STAT_RST = 4'h0;
   localparam logic [BPSL_NSTAT-1:0] BPSL_MASK_RST = 4'h0;
   localparam logic [1:0] BPSL_CTRL_RST = 2'h0;

   localparam logic [1:0] BPSL_RESP_OKAY = 2'h0;
   localparam logic [1:0] BPSL_RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // transaction description that travels with an error event
   typedef enum logic [1:0] {BPSL_READ, BPSL_POSTED_WR, BPSL_DELAYED_WR} bpsl_kind_e;

   typedef struct packed {
      logic valid;
      bpsl_kind_e kind;
      logic upstream;
      logic on_secondary;
   } bpsl_err_s;

   typedef struct packed {
      logic pri_master;
      logic sec_master;
      logic pri_pin;
      logic sec_pin;
   } bpsl_bus_s;

endpackage : bpsl_pkg

/* File: src/bpsl_sticky.sv */
// bpsl_sticky: write-one-to-clear status bits where a new set wins over clear.
// assumes set and clear are single-cycle qualified pulses.
`timescale 1ns/1ps
`default_nettype none
module bpsl_sticky
   import bpsl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic [BPSL_NSTAT-1:0] set,
   input wire logic [BPSL_NSTAT-1:0] clr,
   // state
   output logic [BPSL_NSTAT-1:0] stat_q
);

   logic [BPSL_NSTAT-1:0] stat_d;

   always_comb
   begin
      stat_d = (stat_q & ~clr) | set;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stat_q <= BPSL_STAT_RST;
      end
      else
      begin
         stat_q <= stat_d;
      end
   end

   AST_STICKY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (|(stat_q & ~clr)) |=> (&((stat_q | ~$past(stat_q & ~clr)))))
      else $error("status bit dropped without clear");
   AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
      (|(set & clr)) |=> ((stat_q & $past(set & clr)) == $past(set & clr)))
      else $error("set lost against clear");

endmodule : bpsl_sticky
`default_nettype wire

/* File: src/bpsl_top.sv */
// bpsl_top: parity status logic with axi4-lite registers and one interrupt.
// assumes error events and pin samples are synchronous to CORE_CLK.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module bpsl_top
   import bpsl_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // error event from the bridge datapath
   input wire logic ERR_VALID,
   input wire logic [1:0] ERR_KIND,
   input wire logic ERR_UPSTREAM,
   input wire logic ERR_ON_SECONDARY,
   // bus role and sampled parity error pins, active high here
   input wire logic PRI_MASTER,
   input wire logic SEC_MASTER,
   input wire logic PRIMARY_PARITY_ERROR_PIN,
   input wire logic SECONDARY_PARITY_ERROR_PIN,
   // axi4-lite write address and data
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [3:0] AWADDR,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   // axi4-lite write response
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // axi4-lite read
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [3:0] ARADDR,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // interrupt
   output logic IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // error classification
   bpsl_err_s err;
   bpsl_bus_s bus;
   logic [BPSL_NSTAT-1:0] set;
   logic [BPSL_NSTAT-1:0] clr;
   logic [BPSL_NSTAT-1:0] stat_q;
   logic [BPSL_NSTAT-1:0] mask_q, mask_d;
   logic [1:0] ctrl_q, ctrl_d;

   always_comb
   begin
      err.valid = ERR_VALID;
      err.kind = bpsl_kind_e'(ERR_KIND);
      err.upstream = ERR_UPSTREAM;
      err.on_secondary = ERR_ON_SECONDARY;
      bus.pri_master = PRI_MASTER;
      bus.sec_master = SEC_MASTER;
      bus.pri_pin = PRIMARY_PARITY_ERROR_PIN;
      bus.sec_pin = SECONDARY_PARITY_ERROR_PIN;
   end

   bpsl_classify u_bpsl_classify (
      .err(err),
      .bus(bus),
      .pri_per(ctrl_q[BPSL_BIT_PRI_PER]),
      .sec_per(ctrl_q[BPSL_BIT_SEC_PER]),
      .set(set)
   );

   bpsl_sticky u_bpsl_sticky (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .set(set),
      .clr(clr),
      .stat_q(stat_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write side: address and data latched in either order
   logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
   logic [3:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d;
   logic do_wr;

   assign AWREADY = !aw_have_q && !bvalid_q;
   assign WREADY = !w_have_q && !bvalid_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;

   always_comb
   begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      mask_d = mask_q;
      ctrl_d = ctrl_q;
      clr = '0;
      do_wr = aw_have_q && w_have_q;
      if (AWVALID && AWREADY)
      begin
         aw_have_d = 1'b1;
         awaddr_d = AWADDR;
      end
      if (WVALID && WREADY)
      begin
         w_have_d = 1'b1;
         wdata_d = WDATA;
         wstrb_d = WSTRB;
      end
      if (do_wr)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = BPSL_RESP_OKAY;
         case (awaddr_q)
            BPSL_ADDR_STATUS: clr = wstrb_q[0] ? wdata_q[BPSL_NSTAT-1:0] : '0;
            BPSL_ADDR_MASK: mask_d = wstrb_q[0] ? wdata_q[BPSL_NSTAT-1:0] : mask_q;
            BPSL_ADDR_CTRL: ctrl_d = wstrb_q[0] ? wdata_q[1:0] : ctrl_q;
            BPSL_ADDR_INFO: bresp_d = BPSL_RESP_OKAY;
            default: bresp_d = BPSL_RESP_SLVERR;
         endcase
      end
      if (bvalid_q && BREADY)
      begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= BPSL_RESP_OKAY;
         mask_q <= BPSL_MASK_RST;
         ctrl_q <= BPSL_CTRL_RST;
      end
      else
      begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         mask_q <= mask_d;
         ctrl_q <= ctrl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read side: one cycle to the answer
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   assign ARREADY = !rvalid_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;

   always_comb
   begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (ARVALID && ARREADY)
      begin
         rvalid_d = 1'b1;
         rresp_d = BPSL_RESP_OKAY;
         case (ARADDR)
            BPSL_ADDR_STATUS: rdata_d = {28'h0, stat_q};
            BPSL_ADDR_MASK: rdata_d = {28'h0, mask_q};
            BPSL_ADDR_CTRL: rdata_d = {30'h0, ctrl_q};
            BPSL_ADDR_INFO: rdata_d = {28'h0, set};
            default:
            begin
               rdata_d = 32'h0;
               rresp_d = BPSL_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && RREADY)
      begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= BPSL_RESP_OKAY;
      end
      else
      begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: level, combinational from registered state
   assign IRQ = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_PRI_DET_SET: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (ERR_VALID && !ERR_ON_SECONDARY && ERR_UPSTREAM && ERR_KIND == 2'h0)
      |=> stat_q[BPSL_BIT_PRI_DET])
      else $error("primary detected bit not set on upstream read");
   AST_PRI_DET_ONLY: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($rose(stat_q[BPSL_BIT_PRI_DET])) |->
      $past(ERR_VALID && !ERR_ON_SECONDARY &&
         ((ERR_UPSTREAM && ERR_KIND == BPSL_READ) ||
          (!ERR_UPSTREAM && (ERR_KIND == BPSL_POSTED_WR || ERR_KIND == BPSL_DELAYED_WR)))))
      else $error("primary detected bit set by wrong event");
   AST_SEC_DET_SET: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (ERR_VALID && ERR_ON_SECONDARY && ERR_UPSTREAM &&
       (ERR_KIND == BPSL_POSTED_WR || ERR_KIND == BPSL_DELAYED_WR))
      |=> stat_q[BPSL_BIT_SEC_DET])
      else $error("secondary detected bit not set on upstream write");
   AST_SEC_DET_ONLY: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($rose(stat_q[BPSL_BIT_SEC_DET])) |->
      $past(ERR_VALID && ERR_ON_SECONDARY &&
         ((!ERR_UPSTREAM && ERR_KIND == BPSL_READ) ||
          (ERR_UPSTREAM && (ERR_KIND == BPSL_POSTED_WR || ERR_KIND == BPSL_DELAYED_WR)))))
      else $error("secondary detected bit set by wrong event");
   AST_PRI_MDP_ROLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($rose(stat_q[BPSL_BIT_PRI_MDP])) |-> $past(PRI_MASTER))
      else $error("primary master bit set while target");
   AST_PRI_MDP_EN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($rose(stat_q[BPSL_BIT_PRI_MDP])) |-> $past(ctrl_q[BPSL_BIT_PRI_PER]))
      else $error("primary master bit set with response disabled");
   AST_PRI_MDP_PIN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (PRI_MASTER && PRIMARY_PARITY_ERROR_PIN && ctrl_q[BPSL_BIT_PRI_PER])
      |=> stat_q[BPSL_BIT_PRI_MDP])
      else $error("primary pin not recorded");
   AST_SEC_MDP_ROLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($rose(stat_q[BPSL_BIT_SEC_MDP])) |-> $past(SEC_MASTER))
      else $error("secondary master bit set while target");
   AST_SEC_MDP_EN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($rose(stat_q[BPSL_BIT_SEC_MDP])) |-> $past(ctrl_q[BPSL_BIT_SEC_PER]))
      else $error("secondary master bit set with response disabled");
   AST_SEC_MDP_PIN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (SEC_MASTER && SECONDARY_PARITY_ERROR_PIN && ctrl_q[BPSL_BIT_SEC_PER])
      |=> stat_q[BPSL_BIT_SEC_MDP])
      else $error("secondary pin not recorded");
   AST_RD_ANSWER: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (ARVALID && ARREADY) |=> RVALID)
      else $error("read answer late");
   // own parity check while mastering, independent of the pin sample
   AST_PRI_MDP_OWN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (PRI_MASTER && ctrl_q[BPSL_BIT_PRI_PER] && ERR_VALID && !ERR_ON_SECONDARY &&
       ERR_UPSTREAM) |=> stat_q[BPSL_BIT_PRI_MDP])
      else $error("primary own parity check not recorded");
   AST_SEC_MDP_OWN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (SEC_MASTER && ctrl_q[BPSL_BIT_SEC_PER] && ERR_VALID && ERR_ON_SECONDARY &&
       !ERR_UPSTREAM) |=> stat_q[BPSL_BIT_SEC_MDP])
      else $error("secondary own parity check not recorded");
   AST_WR_ANSWER: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (aw_have_q && w_have_q) |=> BVALID)
      else $error("write answer late");
   AST_WR_REFUSED: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      BVALID |-> (!AWREADY && !WREADY))
      else $error("write accepted while response pending");

   COV_IRQ: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $rose(IRQ));
   COV_CLEAR: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      stat_q[BPSL_BIT_PRI_DET] ##1 !stat_q[BPSL_BIT_PRI_DET]);
   COV_SEC_MDP: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(stat_q[BPSL_BIT_SEC_MDP]));
   COV_SET_CLR: cover property (@(posedge CORE_CLK) disable iff (!RST_N) |(set & clr));

endmodule : bpsl_top
`default_nettype wire

/* File: verification/bpsl_agents.sv */
// bpsl_agents: pci agents on both buses, raising error events and pin samples.
// assumes the bench calls one task at a time, from its own clock domain.
`timescale 1ns/1ps
`default_nettype none
module bpsl_agents
(
   // clock
   input wire logic clk,
   // error event and bus state
   output logic err_valid,
   output logic [1:0] err_kind,
   output logic err_upstream,
   output logic err_on_secondary,
   output logic pri_master,
   output logic sec_master,
   output logic pri_pin,
   output logic sec_pin
);
   initial
   begin
      {err_valid, err_kind, err_upstream, err_on_secondary} = 5'h0;
      {pri_master, sec_master, pri_pin, sec_pin} = 4'h0;
   end
   ////////////////////////////////////////////////////////////
   // fields are inverted outside the pulse so stale values never pass
   task automatic fire(input logic [1:0] k, input logic u, input logic s);
      @(posedge clk);
      err_valid <= 1'b1;
      err_kind <= k;
      err_upstream <= u;
      err_on_secondary <= s;
      @(posedge clk);
      err_valid <= 1'b0;
      err_kind <= ~k;
      err_upstream <= ~u;
      err_on_secondary <= ~s;
   endtask : fire
   task automatic set_role(input logic pm_on, input logic sm_on);
      @(posedge clk);
      pri_master <= pm_on;
      sec_master <= sm_on;
   endtask : set_role
   // pins have pull-ups on the bus, so idle reads inactive here
   task automatic pins();
      @(posedge clk);
      pri_pin <= 1'b1;
      sec_pin <= 1'b1;
      @(posedge clk);
      pri_pin <= 1'b0;
      sec_pin <= 1'b0;
   endtask : pins
endmodule : bpsl_agents
`default_nettype wire

/* File: verification/tb.sv */
// tb: register level test of the parity status logic through axi4-lite.
// assumes single-cycle answers are not relied upon; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module tb
   import bpsl_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic ev, eu, es, pm, sm, pp, sp;
   logic [1:0] ek;
   int num_errors = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   bpsl_agents u_bpsl_agents (.clk(clk), .err_valid(ev), .err_kind(ek),
      .err_upstream(eu), .err_on_secondary(es), .pri_master(pm), .sec_master(sm),
      .pri_pin(pp), .sec_pin(sp));
   bpsl_top u_bpsl_top (.CORE_CLK(clk), .RST_N(rst_n), .ERR_VALID(ev), .ERR_KIND(ek),
      .ERR_UPSTREAM(eu), .ERR_ON_SECONDARY(es), .PRI_MASTER(pm), .SEC_MASTER(sm),
      .PRIMARY_PARITY_ERROR_PIN(pp), .SECONDARY_PARITY_ERROR_PIN(sp),
      .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
      .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
      .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
      .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .IRQ(irq));
   ////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic tmo();
      num_errors++;
      print_verdict();
   endtask : tmo
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // ready is looked at mid-cycle, where it has settled, and acted on at the next edge
   task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ta, tw, aw, w, got;
      int i;
      {aw, w, got} = 3'b000;
      @(posedge clk);
      {awvalid, wvalid, bready} <= 3'b111;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      for (i = 0; i < 50 && !got; i++)
      begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         got = bvalid;
         rs = bresp;
         @(posedge clk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!got)
         tmo();
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ta, got;
      int i;
      got = 1'b0;
      @(posedge clk);
      {arvalid, rready} <= 2'b11;
      araddr <= a;
      for (i = 0; i < 50 && !got; i++)
      begin
         @(negedge clk);
         ta = arvalid && arready;
         got = rvalid;
         v = rdata;
         rs = rresp;
         @(posedge clk);
         if (ta)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!got)
         tmo();
   endtask : rd
   function automatic logic [3:0] exp_stat(int k, int u, int s, int c);
      // kind code 3 carries no detected-bit effect
      exp_stat[0] = !s && k != 3 && (k == 0 ? u : !u);
      exp_stat[1] = s && k != 3 && (k == 0 ? !u : u);
      exp_stat[2] = c[2] && c[0] && !s && u;
      exp_stat[3] = c[2] && c[1] && s && !u;
   endfunction : exp_stat
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 4; a++)
      begin
         rd(4'(a * 4), d, r);
         chk(d, 32'h0);
         chk({30'h0, r}, {30'h0, BPSL_RESP_OKAY});
      end
      // every kind, direction and bus, under each enable pair, with both buses mastered or neither
      for (int c = 0; c < 8; c++)
      begin
         u_bpsl_agents.set_role(c[2], c[2]);
         wr(BPSL_ADDR_CTRL, {30'h0, c[1], c[0]}, r);
         chk({30'h0, r}, {30'h0, BPSL_RESP_OKAY});
         u_bpsl_agents.pins();
         rd(BPSL_ADDR_STATUS, d, r);
         chk(d, {28'h0, c[1] && c[2], c[0] && c[2], 2'b00});
         wr(BPSL_ADDR_STATUS, 32'hF, r);
         for (int k = 0; k < 4; k++)
            for (int u = 0; u < 2; u++)
               for (int s = 0; s < 2; s++)
               begin
                  u_bpsl_agents.fire(2'(k), u[0], s[0]);
                  rd(BPSL_ADDR_STATUS, d, r);
                  chk(d, {28'h0, exp_stat(k, u, s, c)});
                  wr(BPSL_ADDR_STATUS, 32'hF, r);
               end
      end
      // one bus mastered at a time: the secondary master bit stays clear while only the primary is mastered, then joins the sticky primary bit
      u_bpsl_agents.set_role(1'b1, 1'b0);
      u_bpsl_agents.pins();
      rd(BPSL_ADDR_STATUS, d, r);
      chk(d, 32'h4);
      u_bpsl_agents.set_role(1'b0, 1'b1);
      u_bpsl_agents.pins();
      rd(BPSL_ADDR_STATUS, d, r);
      chk(d, 32'hC);
      wr(BPSL_ADDR_STATUS, 32'hF, r);
      u_bpsl_agents.set_role(1'b1, 1'b1);
      // sticky bits, write one to clear, interrupt masking
      u_bpsl_agents.fire(2'h0, 1'b1, 1'b0);
      wr(BPSL_ADDR_STATUS, 32'h0, r);
      rd(BPSL_ADDR_STATUS, d, r);
      chk(d, 32'h5);
      // clear and new event in one cycle: the event must win
      fork
         wr(BPSL_ADDR_STATUS, 32'h1, r);
         begin
            @(posedge clk);
            u_bpsl_agents.fire(2'h0, 1'b1, 1'b0);
         end
      join
      rd(BPSL_ADDR_STATUS, d, r);
      chk(d, 32'h5);
      chk({31'h0, irq}, 32'h0);
      wr(BPSL_ADDR_MASK, 32'h1, r);
      chk({31'h0, irq}, 32'h1);
      wr(BPSL_ADDR_STATUS, 32'h1, r);
      rd(BPSL_ADDR_STATUS, d, r);
      chk(d, 32'h4);
      chk({31'h0, irq}, 32'h0);
      wr(BPSL_ADDR_MASK, 32'hF, r);
      chk({31'h0, irq}, 32'h1);
      wr(BPSL_ADDR_STATUS, 32'hF, r);
      chk({31'h0, irq}, 32'h0);
      wr(4'h6, 32'h0, r);
      chk({30'h0, r}, {30'h0, BPSL_RESP_SLVERR});
      rd(BPSL_ADDR_MASK, d, r);
      chk(d, 32'hF);
      rd(4'h2, d, r);
      chk({30'h0, r}, {30'h0, BPSL_RESP_SLVERR});
      chk(d, 32'h0);
      // second reset in mid-run drops status, mask, enables and the interrupt
      u_bpsl_agents.fire(2'h0, 1'b1, 1'b0);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk({31'h0, irq}, 32'h0);
      for (int a = 0; a < 3; a++)
      begin
         rd(4'(a * 4), d, r);
         chk(d, 32'h0);
      end
      print_verdict();
   end
endmodule : tb
`default_nettype wire
